// ===== mfc_feature_port.sv
// motion feature configuration port: init control, parameter window, error flags
//
// Function
// [RULE1] startup control byte, resets to 0x90, a write starts initialization
// [RULE2] byte window onto parameter words, little-endian at even byte offsets
// [RULE3] activity word 0: 11-bit slope threshold, default 0xAA
// [RULE4] activity word 2: 13-bit duration in 20 ms samples, default 5
// [RULE5] motion event only after threshold held for programmed sample count
// [RULE6] inactivity words at offsets 4 and 6, same layout and defaults
// [RULE7] duration word bits 13..15 enable x, y, z; reset disabled
// [RULE8] remap word at 0x0A resets 0x0088; bits 1..0 pick x source
// [RULE9] remap bit 2 negates x output
// [RULE10] remap bits 4..3 pick y source, default 1, code 3 is y
// [RULE11] remap bit 5 negates y output
// [RULE12] remap bits 7..6 pick z source, default 2, code 3 is z
// [RULE13] remap bit 8 negates z output
// [RULE14] word at offset 8 is reserved storage with no function
// [RULE15] read-only error bit 1 flags overlong processing and halts it
// [RULE16] error bit 2 flags fatal error and halts processing
// [RULE17] host ignores reserved bits of the error register
// [RULE18] activity, inactivity, error routable per pin by map bits 5..7
// [RULE19] while halted no new motion events until reinitialized
`timescale 1ns/1ps
`default_nettype none
module mfc_feature_port (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] acc_x,
  input  wire logic [15:0] acc_y,
  input  wire logic [15:0] acc_z,
  input  wire logic        acc_valid,
  input  wire logic        err_slow,
  input  wire logic        err_fatal,
  output logic      [15:0] rmp_x,
  output logic      [15:0] rmp_y,
  output logic      [15:0] rmp_z,
  output logic             rmp_valid,
  output logic             any_motion_evt,
  output logic             no_motion_evt,
  output logic             init_start,
  output logic             proc_halted,
  output logic             int1_evt,
  output logic             int2_evt
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  init_q;
  logic [7:0]  map1_q;
  logic [7:0]  map2_q;
  logic [2:0]  err_q;
  logic [3:0]  ptr_q;
  logic [15:0] words_q [mfc_pkg::MFC_NUM_WORDS];
  logic        err_evt_q;
  logic        init_wr;
  logic        win_acc;
  logic        win_wr;
  logic        smp_go;
  logic [2:0]  widx;
  logic [15:0] cur_word;
  logic [7:0]  win_byte;
  logic [7:0]  rd_mux;

  function automatic logic [15:0] word_reset(input logic [2:0] idx);
    logic [15:0] r;
    unique case (idx)
      mfc_pkg::MFC_W_ANY_THR, mfc_pkg::MFC_W_NO_THR: r = mfc_pkg::MFC_RST_THR;
      mfc_pkg::MFC_W_ANY_DUR, mfc_pkg::MFC_W_NO_DUR: r = mfc_pkg::MFC_RST_DUR;
      mfc_pkg::MFC_W_REMAP:                          r = mfc_pkg::MFC_RST_REMAP;
      default:                                       r = mfc_pkg::MFC_RST_RSVD;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  assign init_wr  = reg_wr && (reg_addr == mfc_pkg::MFC_ADDR_INIT);
  assign win_acc  = (reg_wr || reg_rd) && (reg_addr == mfc_pkg::MFC_ADDR_WIN);
  assign win_wr   = reg_wr && (reg_addr == mfc_pkg::MFC_ADDR_WIN) && (ptr_q < mfc_pkg::MFC_WIN_BYTES);
  assign widx     = ptr_q[3:1];
  assign cur_word = (ptr_q < mfc_pkg::MFC_WIN_BYTES) ? words_q[widx] : 16'h0000;
  assign win_byte = ptr_q[0] ? cur_word[15:8] : cur_word[7:0];

  // ---------------------------------------------------------------
  // startup control
  // ---------------------------------------------------------------
  // [RULE1] software write starts initialization
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_q     <= mfc_pkg::MFC_RST_INIT;
      init_start <= 1'b0;
    end else begin
      init_start <= init_wr;
      if (init_wr) begin
        init_q <= reg_wdata;
      end
    end
  end

  // [RULE18] per-pin routing registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      map1_q <= mfc_pkg::MFC_RST_MAP;
      map2_q <= mfc_pkg::MFC_RST_MAP;
    end else if (reg_wr) begin
      if (reg_addr == mfc_pkg::MFC_ADDR_MAP1) begin
        map1_q <= reg_wdata & 8'hE0;
      end
      if (reg_addr == mfc_pkg::MFC_ADDR_MAP2) begin
        map2_q <= reg_wdata & 8'hE0;
      end
    end
  end

  // ---------------------------------------------------------------
  // parameter window
  // ---------------------------------------------------------------
  // [RULE2] pointer steps per window byte; any other access rewinds it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr_q <= 4'h0;
    end else if (win_acc) begin
      ptr_q <= (ptr_q >= mfc_pkg::MFC_WIN_BYTES - 4'h1) ? 4'h0 : 4'(ptr_q + 4'h1);
    end else if (reg_wr || reg_rd) begin
      ptr_q <= 4'h0;
    end
  end

  // [RULE3] [RULE4] [RULE6] [RULE8] [RULE14] word storage and defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < mfc_pkg::MFC_NUM_WORDS; i++) begin
        words_q[i] <= word_reset(3'(i));
      end
    end else if (win_wr) begin
      if (ptr_q[0]) begin
        words_q[widx][15:8] <= reg_wdata;
      end else begin
        words_q[widx][7:0] <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // error flags and halt
  // ---------------------------------------------------------------
  // [RULE15] [RULE16] sticky halt flags; a new error beats the init clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_q     <= mfc_pkg::MFC_RST_ERR[2:0];
      err_evt_q <= 1'b0;
    end else begin
      err_q[0]  <= 1'b0;
      err_q[mfc_pkg::MFC_ERR_SLOW]  <= err_slow || (err_q[mfc_pkg::MFC_ERR_SLOW] && !init_wr);
      err_q[mfc_pkg::MFC_ERR_FATAL] <= err_fatal || (err_q[mfc_pkg::MFC_ERR_FATAL] && !init_wr);
      err_evt_q <= (err_slow && !err_q[mfc_pkg::MFC_ERR_SLOW]) || (err_fatal && !err_q[mfc_pkg::MFC_ERR_FATAL]);
    end
  end

  assign proc_halted = err_q[mfc_pkg::MFC_ERR_SLOW] || err_q[mfc_pkg::MFC_ERR_FATAL];
  // [RULE19] halted processing takes no samples
  assign smp_go      = acc_valid && !proc_halted;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      mfc_pkg::MFC_ADDR_INIT: rd_mux = init_q;
      mfc_pkg::MFC_ADDR_WIN:  rd_mux = win_byte;
      // [RULE15] reserved bits read as zero
      mfc_pkg::MFC_ADDR_ERR:  rd_mux = {5'h00, err_q[2:1], 1'b0};
      mfc_pkg::MFC_ADDR_MAP1: rd_mux = map1_q;
      mfc_pkg::MFC_ADDR_MAP2: rd_mux = map2_q;
      default:                rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // data path
  // ---------------------------------------------------------------
  mfc_axis_remap u_remap (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (smp_go),
    .in_x      (acc_x),
    .in_y      (acc_y),
    .in_z      (acc_z),
    .remap     (words_q[mfc_pkg::MFC_W_REMAP]),
    .out_valid (rmp_valid),
    .out_x     (rmp_x),
    .out_y     (rmp_y),
    .out_z     (rmp_z)
  );

  // detectors look at remapped data, so they trail the sample by one cycle
  mfc_motion_det #(.MODE(mfc_pkg::MFC_ANY_MOTION)) u_any (
    .clk       (clk),
    .nrst      (nrst),
    .restart   (init_wr),
    .smp_valid (rmp_valid && !proc_halted),
    .smp_x     (rmp_x),
    .smp_y     (rmp_y),
    .smp_z     (rmp_z),
    .thr       (words_q[mfc_pkg::MFC_W_ANY_THR][mfc_pkg::MFC_THR_MSB:0]),
    .dur       (words_q[mfc_pkg::MFC_W_ANY_DUR][mfc_pkg::MFC_DUR_MSB:0]),
    .axis_en   (words_q[mfc_pkg::MFC_W_ANY_DUR][mfc_pkg::MFC_EN_LSB+:3]),
    .evt       (any_motion_evt)
  );

  mfc_motion_det #(.MODE(mfc_pkg::MFC_NO_MOTION)) u_no (
    .clk       (clk),
    .nrst      (nrst),
    .restart   (init_wr),
    .smp_valid (rmp_valid && !proc_halted),
    .smp_x     (rmp_x),
    .smp_y     (rmp_y),
    .smp_z     (rmp_z),
    .thr       (words_q[mfc_pkg::MFC_W_NO_THR][mfc_pkg::MFC_THR_MSB:0]),
    .dur       (words_q[mfc_pkg::MFC_W_NO_DUR][mfc_pkg::MFC_DUR_MSB:0]),
    .axis_en   (words_q[mfc_pkg::MFC_W_NO_DUR][mfc_pkg::MFC_EN_LSB+:3]),
    .evt       (no_motion_evt)
  );

  // [RULE18] event routing to the two pins
  assign int1_evt = (any_motion_evt && map1_q[mfc_pkg::MFC_MAP_ANY]) || (no_motion_evt && map1_q[mfc_pkg::MFC_MAP_NO])
                    || (err_evt_q && map1_q[mfc_pkg::MFC_MAP_ERR]);
  assign int2_evt = (any_motion_evt && map2_q[mfc_pkg::MFC_MAP_ANY]) || (no_motion_evt && map2_q[mfc_pkg::MFC_MAP_NO])
                    || (err_evt_q && map2_q[mfc_pkg::MFC_MAP_ERR]);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_init_start_pulse: assert property (@(posedge clk) disable iff (!nrst) // [RULE1]
    init_wr |=> init_start && init_q == $past(reg_wdata))
    else $error("init write did not start initialization");

  a_win_ptr_step: assert property (@(posedge clk) disable iff (!nrst) // [RULE2]
    win_acc && ptr_q < 4'hB |=> ptr_q == 4'($past(ptr_q) + 4'h1))
    else $error("window pointer did not step");

  a_err_slow_set: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
    err_slow |=> err_q[1] && proc_halted)
    else $error("slow processing flag not set");

  a_err_fatal_set: assert property (@(posedge clk) disable iff (!nrst) // [RULE16]
    err_fatal |=> err_q[2] ##0 err_q[2] [*1] ##1 (err_q[2] || $past(init_wr)))
    else $error("fatal flag not held");

  a_err_rd_zero: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
    reg_rd && reg_addr == mfc_pkg::MFC_ADDR_ERR |=> reg_rdata[7:3] == 5'h00 && !reg_rdata[0])
    else $error("reserved error bits not zero");

  a_halt_no_events: assert property (@(posedge clk) disable iff (!nrst) // [RULE19]
    proc_halted |=> !any_motion_evt && !no_motion_evt)
    else $error("motion event while halted");

  a_route_pin_one: assert property (@(posedge clk) disable iff (!nrst) // [RULE18]
    any_motion_evt && map1_q[5] |-> int1_evt)
    else $error("routed event missing on pin one");

  a_remap_default: assert property (@(posedge clk) disable iff (!nrst) // [RULE8]
    smp_go && words_q[5] == 16'h0088 |=> rmp_valid && rmp_x == $past(acc_x)
    && rmp_y == $past(acc_y) && rmp_z == $past(acc_z))
    else $error("default remap not identity");

  a_win_ptr_wrap: assert property (@(posedge clk) disable iff (!nrst) // [RULE2]
    win_acc && ptr_q == 4'hB |=> ptr_q == 4'h0)
    else $error("window pointer did not wrap");

  a_err_wr_ignored: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
    reg_wr && reg_addr == mfc_pkg::MFC_ADDR_ERR && !err_slow && !err_fatal |=> $stable(err_q))
    else $error("error flags changed by a write");

  a_map_keeps_bits: assert property (@(posedge clk) disable iff (!nrst) // [RULE18]
    reg_wr && reg_addr == mfc_pkg::MFC_ADDR_MAP1 |=> map1_q == ($past(reg_wdata) & 8'hE0))
    else $error("routing register holds wrong bits");

  a_init_clears_halt: assert property (@(posedge clk) disable iff (!nrst) // [RULE19]
    init_wr && !err_slow && !err_fatal |=> !proc_halted)
    else $error("init write did not clear halt");

  a_halt_drops_smp: assert property (@(posedge clk) disable iff (!nrst) // [RULE19]
    proc_halted |=> !rmp_valid)
    else $error("sample taken while halted");

  c_any_event: cover property (@(posedge clk) disable iff (!nrst) any_motion_evt);
  c_no_event:  cover property (@(posedge clk) disable iff (!nrst) no_motion_evt);
  c_halted:    cover property (@(posedge clk) disable iff (!nrst) proc_halted ##1 init_wr);
  c_win_burst: cover property (@(posedge clk) disable iff (!nrst) win_wr ##2 win_wr);
endmodule
`default_nettype wire

// ===== mfc_pkg.sv
// constants for the motion feature configuration port
package mfc_pkg;
  // ---------------------------------------------------------------
  // register addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MFC_ADDR_MAP1 = 8'h56;
  localparam logic [7:0] MFC_ADDR_MAP2 = 8'h57;
  localparam logic [7:0] MFC_ADDR_INIT = 8'h59;
  localparam logic [7:0] MFC_ADDR_WIN  = 8'h5E;
  localparam logic [7:0] MFC_ADDR_ERR  = 8'h5F;
  localparam logic [7:0] MFC_RST_INIT  = 8'h90;
  localparam logic [7:0] MFC_RST_WIN   = 8'h00;
  localparam logic [7:0] MFC_RST_ERR   = 8'h00;
  localparam logic [7:0] MFC_RST_MAP   = 8'h00;
  // ---------------------------------------------------------------
  // parameter words behind the window (word indices)
  // ---------------------------------------------------------------
  localparam int         MFC_NUM_WORDS  = 6;
  localparam logic [3:0] MFC_WIN_BYTES  = 4'hC;
  localparam logic [2:0] MFC_W_ANY_THR  = 3'h0;
  localparam logic [2:0] MFC_W_ANY_DUR  = 3'h1;
  localparam logic [2:0] MFC_W_NO_THR   = 3'h2;
  localparam logic [2:0] MFC_W_NO_DUR   = 3'h3;
  localparam logic [2:0] MFC_W_RSVD     = 3'h4;
  localparam logic [2:0] MFC_W_REMAP    = 3'h5;
  localparam logic [15:0] MFC_RST_THR   = 16'h00AA;
  localparam logic [15:0] MFC_RST_DUR   = 16'h0005;
  localparam logic [15:0] MFC_RST_RSVD  = 16'h0000;
  localparam logic [15:0] MFC_RST_REMAP = 16'h0088;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MFC_THR_MSB    = 10;
  localparam int MFC_DUR_MSB    = 12;
  localparam int MFC_EN_LSB     = 13;
  localparam int MFC_SRC_X_LSB  = 0;
  localparam int MFC_SIGN_X     = 2;
  localparam int MFC_SRC_Y_LSB  = 3;
  localparam int MFC_SIGN_Y     = 5;
  localparam int MFC_SRC_Z_LSB  = 6;
  localparam int MFC_SIGN_Z     = 8;
  localparam int MFC_ERR_SLOW   = 1;
  localparam int MFC_ERR_FATAL  = 2;
  localparam int MFC_MAP_ANY    = 5;
  localparam int MFC_MAP_NO     = 6;
  localparam int MFC_MAP_ERR    = 7;
  localparam logic [1:0] MFC_SEL_X = 2'h0;
  localparam logic [1:0] MFC_SEL_Y = 2'h1;
  localparam logic [1:0] MFC_SEL_Z = 2'h2;

  typedef enum logic {MFC_ANY_MOTION, MFC_NO_MOTION} mfc_mode_type;
endpackage

// ===== mfc_axis_remap.sv
// axis remapping with per-axis sign inversion
`timescale 1ns/1ps
`default_nettype none
module mfc_axis_remap (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        in_valid,
  input  wire logic [15:0] in_x,
  input  wire logic [15:0] in_y,
  input  wire logic [15:0] in_z,
  input  wire logic [15:0] remap,
  output logic             out_valid,
  output logic      [15:0] out_x,
  output logic      [15:0] out_y,
  output logic      [15:0] out_z
);
  // reserved code 3 falls back to the axis' own source
  function automatic logic [15:0] pick(input logic [1:0] sel, input logic [1:0] own, input logic sign,
                                       input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    logic [1:0]  s;
    logic [15:0] v;
    s = (sel == 2'h3) ? own : sel;
    unique case (s)
      mfc_pkg::MFC_SEL_X: v = x;
      mfc_pkg::MFC_SEL_Y: v = y;
      default:            v = z;
    endcase
    return sign ? 16'(-v) : v;
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_x <= 16'h0000;
      out_y <= 16'h0000;
      out_z <= 16'h0000;
    end else if (in_valid) begin
      // [RULE8] x source select
      // [RULE9] x sign
      out_x <= pick(remap[mfc_pkg::MFC_SRC_X_LSB+:2], mfc_pkg::MFC_SEL_X, remap[mfc_pkg::MFC_SIGN_X],
                    in_x, in_y, in_z);
      // [RULE10] y source select
      // [RULE11] y sign
      out_y <= pick(remap[mfc_pkg::MFC_SRC_Y_LSB+:2], mfc_pkg::MFC_SEL_Y, remap[mfc_pkg::MFC_SIGN_Y],
                    in_x, in_y, in_z);
      // [RULE12] z source select
      // [RULE13] z sign
      out_z <= pick(remap[mfc_pkg::MFC_SRC_Z_LSB+:2], mfc_pkg::MFC_SEL_Z, remap[mfc_pkg::MFC_SIGN_Z],
                    in_x, in_y, in_z);
    end
  end
endmodule
`default_nettype wire

// ===== mfc_motion_det.sv
// slope based any-motion / no-motion detector
`timescale 1ns/1ps
`default_nettype none
module mfc_motion_det #(
  parameter mfc_pkg::mfc_mode_type MODE = mfc_pkg::MFC_ANY_MOTION
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        restart,
  input  wire logic        smp_valid,
  input  wire logic [15:0] smp_x,
  input  wire logic [15:0] smp_y,
  input  wire logic [15:0] smp_z,
  input  wire logic [10:0] thr,
  input  wire logic [12:0] dur,
  input  wire logic [2:0]  axis_en,
  output logic             evt
);
  logic [47:0] prev_q;
  logic        prev_ok_q;
  logic [12:0] run_q;
  logic [2:0]  over;
  logic        cond;
  logic [12:0] run_n;
  logic [12:0] dur_eff;

  function automatic logic slope_over(input logic [15:0] a, input logic [15:0] b, input logic [10:0] t);
    logic [16:0] d;
    d = 17'({a[15], a}) - 17'({b[15], b});
    if (d[16]) begin
      d = 17'(-d);
    end
    return d > {6'h00, t};
  endfunction

  always_comb begin
    over[0] = slope_over(smp_x, prev_q[15:0], thr);
    over[1] = slope_over(smp_y, prev_q[31:16], thr);
    over[2] = slope_over(smp_z, prev_q[47:32], thr);
    // [RULE7] disabled axes take no part
    if (MODE == mfc_pkg::MFC_ANY_MOTION) begin
      cond = |(axis_en & over);
    end else begin
      cond = (axis_en != 3'h0) && ((axis_en & over) == 3'h0);
    end
    cond    = cond && prev_ok_q;
    run_n   = (run_q == 13'h1FFF) ? run_q : 13'(run_q + 13'h1);
    dur_eff = (dur == 13'h0000) ? 13'h0001 : dur;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q    <= 48'h0;
      prev_ok_q <= 1'b0;
    end else if (restart) begin
      prev_ok_q <= 1'b0;
    end else if (smp_valid) begin
      prev_q    <= {smp_z, smp_y, smp_x};
      prev_ok_q <= 1'b1;
    end
  end

  // [RULE5] event only after dur consecutive qualifying samples
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 13'h0000;
      evt   <= 1'b0;
    end else begin
      evt <= 1'b0;
      if (restart) begin
        run_q <= 13'h0000;
      end else if (smp_valid) begin
        run_q <= cond ? run_n : 13'h0000;
        evt   <= cond && (run_n == dur_eff);
      end
    end
  end

  // [RULE5]
  a_evt_has_cause: assert property (@(posedge clk) disable iff (!nrst)
    evt |-> $past(smp_valid) && $past(cond) && run_q == $past(dur_eff))
    else $error("motion event without a completed run");
endmodule
`default_nettype wire

// ===== mfc_host.sv
// host processor model that drives the byte-wide register bus
`timescale 1ns/1ps
`default_nettype none
module mfc_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // released lines show the inverse so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask

  task automatic rd_err(output logic [7:0] d);
    rd(8'h5F, d);
    d = d & 8'h06;
  endtask
endmodule
`default_nettype wire

// ===== motion_feature_config_port_tb.sv
// self-checking bench for the motion feature configuration port
`timescale 1ns/1ps
`default_nettype none
module motion_feature_config_port_tb;
  logic        clk, nrst, reg_wr, reg_rd, acc_valid, err_slow, err_fatal, prim, halted;
  logic        rmp_valid, any_motion_evt, no_motion_evt, init_start, proc_halted, int1_evt, int2_evt;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rb, iv, map1, map2;
  logic [15:0] acc_x, acc_y, acc_z, rmp_x, rmp_y, rmp_z, msk;
  logic [15:0] cfg [6];
  logic [15:0] prv [3];
  int          fails, checks_done, cyc, seed, i, j;
  int          cnt [2];

  initial clk = 1'b0;
  always #5 clk = ~clk;

  mfc_feature_port dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_x(acc_x), .acc_y(acc_y),
    .acc_z(acc_z), .acc_valid(acc_valid), .err_slow(err_slow), .err_fatal(err_fatal),
    .rmp_x(rmp_x), .rmp_y(rmp_y), .rmp_z(rmp_z), .rmp_valid(rmp_valid),
    .any_motion_evt(any_motion_evt), .no_motion_evt(no_motion_evt), .init_start(init_start),
    .proc_halted(proc_halted), .int1_evt(int1_evt), .int2_evt(int2_evt));
  mfc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ---------------------------------------------------------------
  // reference functions and checking
  // ---------------------------------------------------------------
  function automatic logic [15:0] remap_one(input logic [2:0] f, input logic [1:0] own,
                                            input logic [15:0] x, y, z);
    logic [1:0] s;
    s = (f[1:0] == 2'h3) ? own : f[1:0];
    return f[2] ? -((s == 2'h0) ? x : (s == 2'h1) ? y : z) : ((s == 2'h0) ? x : (s == 2'h1) ? y : z);
  endfunction

  function automatic logic [16:0] slope(input logic [15:0] a, b);
    logic signed [16:0] d;
    d = $signed({a[15], a}) - $signed({b[15], b});
    return d[16] ? -d : d;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // a hang is cut short well beyond the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // register tasks
  // ---------------------------------------------------------------
  task automatic get_cfg();
    host.rd(8'h5A, rb);
    chk(rb, 8'h00);
    for (int n = 0; n < 12; n++) begin
      host.rd(8'h5E, rb);
      chk(rb, cfg[n/2][8*(n%2) +: 8]);
    end
  endtask

  task automatic put_cfg();
    host.rd(8'h5A, rb);
    for (int n = 0; n < 12; n++) host.wr(8'h5E, cfg[n/2][8*(n%2) +: 8]);
    get_cfg();
  endtask

  task automatic put_map();
    map1 = $random(seed);
    map2 = $random(seed);
    host.wr(8'h56, map1);
    host.wr(8'h57, map2);
    map1 &= 8'hE0;
    map2 &= 8'hE0;
    host.rd(8'h56, rb);
    chk(rb, map1);
    host.rd(8'h57, rb);
    chk(rb, map2);
  endtask

  task automatic do_init();
    iv = $random(seed);
    host.wr(8'h59, iv);
    chk(init_start, 1'b1);
    host.rd(8'h59, rb);
    chk(rb, iv);
    prim   = 1'b0;
    halted = 1'b0;
    cnt    = '{0, 0};
  endtask

  // detectors see remapped data; a dropped sample leaves the model untouched
  task automatic sample(input logic [15:0] x, y, z);
    logic [15:0] r [3];
    logic [2:0]  ov, en;
    logic        q;
    logic        e [2];
    r[0] = remap_one(cfg[5][2:0], 2'h0, x, y, z);
    r[1] = remap_one(cfg[5][5:3], 2'h1, x, y, z);
    r[2] = remap_one(cfg[5][8:6], 2'h2, x, y, z);
    e    = '{1'b0, 1'b0};
    if (!halted) begin
      for (int k = 0; k < 2; k++) begin
        en = cfg[2*k+1][15:13];
        for (int a = 0; a < 3; a++) ov[a] = slope(r[a], prv[a]) > cfg[2*k][10:0];
        q = (k == 0) ? |(ov & en) : (|en && !(|(ov & en)));
        cnt[k] = (q && prim) ? cnt[k] + 1 : 0;
        e[k] = cnt[k] == ((cfg[2*k+1][12:0] == 13'h0) ? 1 : int'(cfg[2*k+1][12:0]));
      end
      prim = 1'b1;
      prv  = r;
    end
    @(negedge clk);
    acc_x     = x;
    acc_y     = y;
    acc_z     = z;
    acc_valid = 1'b1;
    @(negedge clk);
    acc_valid = 1'b0;
    chk(rmp_valid, !halted);
    if (!halted) begin
      chk(rmp_x, r[0]);
      chk(rmp_y, r[1]);
      chk(rmp_z, r[2]);
    end
    @(negedge clk);
    chk(any_motion_evt, e[0]);
    chk(no_motion_evt, e[1]);
    chk(int1_evt, (map1[5] & e[0]) | (map1[6] & e[1]));
    chk(int2_evt, (map2[5] & e[0]) | (map2[6] & e[1]));
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed      = 32'h5abe72b9;
    nrst      = 1'b0;
    acc_x     = 16'h0000;
    acc_y     = 16'h0000;
    acc_z     = 16'h0000;
    acc_valid = 1'b0;
    err_slow  = 1'b0;
    err_fatal = 1'b0;
    map1      = 8'h00;
    map2      = 8'h00;
    prim      = 1'b0;
    halted    = 1'b0;
    cfg = '{mfc_pkg::MFC_RST_THR, mfc_pkg::MFC_RST_DUR, mfc_pkg::MFC_RST_THR,
            mfc_pkg::MFC_RST_DUR, mfc_pkg::MFC_RST_RSVD, mfc_pkg::MFC_RST_REMAP};
    repeat (8) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    host.rd(8'h59, rb);
    chk(rb, 8'h90);
    host.rd_err(rb);
    chk(rb, 8'h00);
    get_cfg();
    // default remap and disabled axes: identity data, no events
    for (j = 0; j < 4; j++) sample($random(seed), $random(seed), $random(seed));
    $display("reset value test done");
    // every source code on all three axes, wide and near-threshold slopes
    for (i = 0; i < 16; i++) begin
      for (j = 0; j < 5; j++) cfg[j] = $random(seed);
      cfg[5] = $random(seed);
      msk    = (i < 8) ? 16'hFFFF : 16'h001F;
      cfg[0] &= 16'h07FF & msk;
      cfg[2] &= 16'h07FF & msk;
      cfg[1] &= 16'hE003;
      cfg[3] &= 16'hE003;
      cfg[5] &= 16'h01FF;
      cfg[5][1:0] = i[1:0];
      cfg[5][4:3] = i[1:0];
      cfg[5][7:6] = i[1:0];
      put_cfg();
      put_map();
      do_init();
      for (j = 0; j < 12; j++) sample($random(seed) & msk, $random(seed) & msk, $random(seed) & msk);
    end
    $display("remap and detector test done");
    for (i = 0; i < 2; i++) begin
      put_map();
      @(negedge clk);
      err_slow  = (i == 0);
      err_fatal = (i == 1);
      @(negedge clk);
      err_slow  = 1'b0;
      err_fatal = 1'b0;
      halted    = 1'b1;
      chk(proc_halted, 1'b1);
      chk(int1_evt, map1[7]);
      chk(int2_evt, map2[7]);
      host.wr(8'h5F, 8'hFF);
      host.rd_err(rb);
      chk(rb, (i == 0) ? 8'h02 : 8'h04);
      sample(16'h7FFF, 16'h8000, 16'h1234);
      sample(16'h0000, 16'h0000, 16'h0000);
      do_init();
      chk(proc_halted, 1'b0);
      host.rd_err(rb);
      chk(rb, 8'h00);
      sample(16'h0100, 16'h0200, 16'h0300);
    end
    $display("error flag test done");
    summarize();
  end
endmodule
`default_nettype wire
